// ==== bench/gapc_core_tb.sv ====
// Purpose: Directed scenarios for the address/poll/clear core
// Assumes: Inputs change on the falling edge
// Notes:   A stalled controller keeps queue data in view
module gapc_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import gapc_pkg::*;
   logic clk, reset, my_talk_addr, other_talk_addr, my_listen_addr, unlisten;
   logic ifc, spe, spd, dcl, sdc, gtl, llo, ren, mla_remote, local_key;
   logic set_service_mask_cmd, query_service_mask_cmd, clear_all_cmd;
   logic data_valid, data_ready, tx_take, tx_valid, talker, listener;
   logic remote, lockout, poll_mode, srq, service_request_lamp;
   logic input_flush, clear_pulse, hold;
   logic [CAUSE_W-1:0] mask_value, cause_events, service_mask;
   logic [BYTE_W-1:0]  data_in, tx_byte;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;

   gapc_core dut (.*);
   gapc_ctrl_model ctrl (.*);

   // Clock
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         test_done();
      end
   end

   task test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   // One-cycle pulse; returns once its effect has landed
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge clk) s = 0;
   endtask
   task automatic put(logic [7:0] b);
      data_in = b;
      data_valid = 1;
      // Ready is judged at the falling edge, where it has settled
      while (data_ready !== 1'b1) @(negedge clk);
      @(negedge clk) data_valid = 0;
   endtask
   task automatic wait_tx(logic [7:0] e);
      for (int i = 0; i < 8 && tx_valid !== 1'b1; i++) @(negedge clk);
      chk("tx_valid", 1, tx_valid);
      chk("tx_byte", e, tx_byte);
      @(negedge clk);
   endtask

   task s_addr;
      pulse(my_talk_addr);
      chk("talker", 1, talker);
      pulse(other_talk_addr);
      chk("talker", 0, talker);
      pulse(my_listen_addr);
      chk("listener", 1, listener);
      pulse(unlisten);
      chk("listener", 0, listener);
   endtask
   task s_poll;
      pulse(my_talk_addr);
      mask_value = 6'h01;
      pulse(set_service_mask_cmd);
      chk("mask", 8'h01, service_mask);
      cause_events = 6'h01;
      @(negedge clk) cause_events = 6'h00;
      chk("srq", 1, srq);
      chk("lamp", 1, service_request_lamp);
      pulse(spe);
      chk("poll", 1, poll_mode);
      wait_tx(8'h41);
      @(negedge clk) chk("srq", 0, srq);
      cause_events = 6'h02;
      @(negedge clk) cause_events = 6'h00;
      @(negedge clk) chk("srq", 0, srq);
      pulse(spd);
      chk("poll", 0, poll_mode);
      put(8'h5A);
      wait_tx(8'h5A);
      pulse(query_service_mask_cmd);
      wait_tx(8'h01);
      pulse(spe);
      pulse(ifc);
      chk("poll", 0, poll_mode);
      chk("talker", 0, talker);
   endtask
   task s_clear;
      hold = 1;
      pulse(my_talk_addr);
      put(8'h33);
      repeat (3) @(negedge clk);
      pulse(dcl);
      chk("flush", 0, input_flush);
      @(negedge clk) chk("clear", 0, clear_pulse);
      pulse(mla_remote);
      chk("remote", 1, remote);
      for (int k = 0; k < 2; k++) begin
         put(8'h33);
         repeat (3) @(negedge clk);
         if (k == 0) pulse(dcl);
         else pulse(sdc);
         chk("flush", 1, input_flush);
         @(negedge clk) chk("clear", 1, clear_pulse);
         chk("tx_valid", 0, tx_valid);
      end
      put(8'h33);
      repeat (3) @(negedge clk);
      pulse(clear_all_cmd);
      chk("clear", 1, clear_pulse);
      chk("ready", 0, data_ready);
      repeat (2) @(negedge clk);
      chk("tx_valid", 0, tx_valid);
      chk("ready", 1, data_ready);
      hold = 0;
   endtask
   task s_local;
      pulse(gtl);
      chk("remote", 0, remote);
      pulse(mla_remote);
      pulse(local_key);
      chk("remote", 0, remote);
      pulse(mla_remote);
      pulse(llo);
      chk("lockout", 1, lockout);
      pulse(local_key);
      chk("remote", 1, remote);
      ren = 0;
      repeat (2) @(negedge clk);
      chk("remote", 0, remote);
      chk("lockout", 0, lockout);
   endtask

   // Main sequence
   initial begin
      {my_talk_addr, other_talk_addr, my_listen_addr, unlisten, ifc} = '0;
      {spe, spd, dcl, sdc, gtl, llo, mla_remote, local_key} = '0;
      {set_service_mask_cmd, query_service_mask_cmd, clear_all_cmd} = '0;
      {data_valid, hold} = '0;
      ren = 1;
      mask_value = 6'h00;
      cause_events = 6'h00;
      data_in = 8'h00;
      reset = 1;
      repeat (16) @(posedge clk);
      @(negedge clk) reset = 0;
      s_addr();
      s_poll();
      s_clear();
      s_local();
      test_done();
   end
endmodule

// ==== bench/gapc_ctrl_model.sv ====
// Purpose: Controller stand-in that accepts talker bytes
// Assumes: Takes a byte whenever it is not held off
// Notes:   Hold models a slow controller, so a byte must wait
module gapc_ctrl_model (
   // Clock and control
   input  wire logic clk,
   input  wire logic hold,
   // Talker handshake
   output logic      tx_take
);
   timeunit 1ns;
   timeprecision 1ns;
   // Acceptance only changes just after an edge
   always_ff @(posedge clk) tx_take <= !hold;
endmodule

// ==== bench/gapc_properties.sv ====
// Purpose: Concurrent checks on the core's ports
// Assumes: Single clock domain, async high reset
// Notes:   Bound to every instance of the core
module gapc_properties
   import gapc_pkg::*;
(
   input wire logic               clk,
   input wire logic               reset,
   input wire logic               other_talk_addr,
   input wire logic               unlisten,
   input wire logic               ifc,
   input wire logic               spe,
   input wire logic               spd,
   input wire logic               dcl,
   input wire logic               sdc,
   input wire logic               gtl,
   input wire logic               ren,
   input wire logic               set_service_mask_cmd,
   input wire logic [CAUSE_W-1:0] mask_value,
   input wire logic               talker,
   input wire logic               listener,
   input wire logic               remote,
   input wire logic               poll_mode,
   input wire logic               srq,
   input wire logic               service_request_lamp,
   input wire logic [CAUSE_W-1:0] service_mask,
   input wire logic               input_flush,
   input wire logic               clear_pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_OTHER_TALK: assert property (other_talk_addr |=> !talker)
      else $error("talker kept after other talk address");
   AST_UNLISTEN: assert property (unlisten |=> !listener)
      else $error("listener kept after unlisten");
   AST_LAMP: assert property (srq |-> service_request_lamp)
      else $error("lamp dark during service request");
   AST_MASK_LOAD: assert property (set_service_mask_cmd
      |=> service_mask == $past(mask_value))
      else $error("mask not loaded");
   AST_MASKED: assert property ((service_mask == 6'h00)[*3] |-> !srq)
      else $error("service request with all causes masked");
   AST_POLL_OFF: assert property (spd |=> !poll_mode)
      else $error("poll mode kept after disable");
   AST_POLL_HOLD: assert property ((spe || poll_mode) && !spd && !ifc
      |=> poll_mode)
      else $error("poll mode not entered or not held");
   AST_IFC: assert property (ifc |=> !poll_mode && !talker && !listener)
      else $error("state kept after interface clear");
   AST_LOCAL_CLR: assert property ((dcl || sdc) && !remote
      |=> !input_flush)
      else $error("clear honoured in local");
   AST_CLEAR: assert property ((dcl || sdc) && remote
      |=> input_flush ##1 (clear_pulse && !input_flush))
      else $error("clear sequence wrong");
   AST_GO_LOCAL: assert property (gtl || !ren |=> !remote)
      else $error("remote kept after go to local");
endmodule

bind gapc_core gapc_properties chk_i (.*);

// ==== core/gapc_core.sv ====
// Purpose: Talker/listener drop, serial poll, service request, clear
// Assumes: Bus messages decoded elsewhere into one-cycle pulses, with REN held as a level
// Notes:   Output queue is a small ring; reads take two cycles
//
// Contract
// - Other talk address drops talker state
// - Serial poll mode sends status when talker
// - Poll disable restores normal data output
// - Unlisten drops listener state
// - Service request lights the front lamp
// - Per-cause mask gates service request; set-mask loads
// - Mask query returns current mask value
// - Universal device clear ignored in local
// - Remote clear flushes input, then clear-all
// - Universal and selected clear behave identically
// - Output queue emptied on power-up, clear-all, clears
// - Go local on GTL, REN low, key unless locked out
module gapc_core
   import gapc_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Decoded bus messages (pulses; ren is a level)
   input  wire logic                   my_talk_addr,
   input  wire logic                   other_talk_addr,
   input  wire logic                   my_listen_addr,
   input  wire logic                   unlisten,
   input  wire logic                   ifc,
   input  wire logic                   spe,
   input  wire logic                   spd,
   input  wire logic                   dcl,
   input  wire logic                   sdc,
   input  wire logic                   gtl,
   input  wire logic                   llo,
   input  wire logic                   ren,
   input  wire logic                   mla_remote,
   // Front panel
   input  wire logic                   local_key,
   // Device commands (pulses)
   input  wire logic                   set_service_mask_cmd,
   input  wire logic [CAUSE_W-1:0]     mask_value,
   input  wire logic                   query_service_mask_cmd,
   input  wire logic                   clear_all_cmd,
   input  wire logic [CAUSE_W-1:0]     cause_events,
   // Data to send
   input  wire logic                   data_valid,
   input  wire logic [BYTE_W-1:0]      data_in,
   output logic                        data_ready,
   // Talker byte handshake
   input  wire logic                   tx_take,
   output logic                        tx_valid,
   output logic      [BYTE_W-1:0]      tx_byte,
   // State outputs
   output logic                        talker,
   output logic                        listener,
   output logic                        remote,
   output logic                        lockout,
   output logic                        poll_mode,
   output logic                        srq,
   output logic                        service_request_lamp,
   output logic      [CAUSE_W-1:0]     service_mask,
   output logic                        input_flush,
   output logic                        clear_pulse
);
   typedef struct packed {
      logic                talker;
      logic                listener;
      logic                remote;
      logic                lockout;
      logic                poll_mode;
      logic [CAUSE_W-1:0]  mask;
      logic [CAUSE_W-1:0]  pending;
      logic                srq;
      logic                lamp;
      logic                flush;
      logic                clear;
      logic [Q_AW:0]       wr_ptr;
      logic [Q_AW:0]       rd_ptr;
      logic                rd_wait;
      logic                mask_pend;
      logic                tx_valid;
      logic [BYTE_W-1:0]   tx_byte;
      gapc_tx_t            tx_src;
      logic                ready;
   } gapc_state_t;

   gapc_state_t   s_reg;
   gapc_state_t   s_next;
   logic [BYTE_W-1:0] q_rd_data;
   logic          q_wr;
   logic          q_empty;
   logic          q_full;
   logic          dev_clear;
   logic [BYTE_W-1:0] status_byte;

   // Queue flags and status byte
   assign q_empty   = (s_reg.wr_ptr == s_reg.rd_ptr);
   assign q_full    = (s_reg.wr_ptr[Q_AW] != s_reg.rd_ptr[Q_AW]) &&
                      (s_reg.wr_ptr[Q_AW-1:0] == s_reg.rd_ptr[Q_AW-1:0]);
   assign q_wr      = data_valid && !q_full && !s_reg.clear;
   // Both clear messages funnel into one term, local mode blocks both
   assign dev_clear = (dcl || sdc) && s_reg.remote;
   always_comb begin
      status_byte = {2'b00, s_reg.pending};
      status_byte[RSV_BIT] = s_reg.srq;
   end

   gapc_queue_mem u_mem (
      .clk     (clk),
      .wr_en   (q_wr),
      .wr_addr (s_reg.wr_ptr[Q_AW-1:0]),
      .wr_data (data_in),
      .rd_addr (s_reg.rd_ptr[Q_AW-1:0]),
      .rd_data (q_rd_data)
   );

   // Next-state logic
   always_comb begin
      s_next       = s_reg;
      s_next.flush = 1'b0;
      s_next.clear = 1'b0;

      // Addressing; IFC untalks and unlistens
      if (my_talk_addr) begin
         s_next.talker = 1'b1;
      end
      if (other_talk_addr) begin
         s_next.talker = 1'b0;
      end
      if (my_listen_addr) begin
         s_next.listener = 1'b1;
      end
      if (unlisten) begin
         s_next.listener = 1'b0;
      end

      // Remote/local and lockout
      if (mla_remote && ren) begin
         s_next.remote = 1'b1;
      end
      if (llo && ren) begin
         s_next.lockout = 1'b1;
      end
      if (gtl || (local_key && !s_reg.lockout)) begin
         s_next.remote = 1'b0;
      end
      if (!ren) begin
         s_next.remote  = 1'b0;
         s_next.lockout = 1'b0;
      end

      // Serial poll mode
      if (spe) begin
         s_next.poll_mode = 1'b1;
      end
      if (spd) begin
         s_next.poll_mode = 1'b0;
      end

      // Mask load and query
      if (set_service_mask_cmd) begin
         s_next.mask = mask_value;
      end
      if (query_service_mask_cmd) begin
         s_next.mask_pend = 1'b1;
      end

      // New causes set over any clear in the same cycle
      s_next.pending = s_reg.pending | cause_events;

      // Queue write
      if (q_wr) begin
         s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
      end

      // Talker output; poll status takes priority over data
      if (s_reg.tx_valid && tx_take) begin
         s_next.tx_valid = 1'b0;
         if (s_reg.tx_src == GAPC_TX_DATA) begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
         end
         if (s_reg.tx_src == GAPC_TX_MASK) begin
            s_next.mask_pend = 1'b0;
         end
         if (s_reg.tx_src == GAPC_TX_STATUS) begin
            s_next.pending = cause_events; // Poll answer acknowledges
         end
      end else if (!s_reg.tx_valid && s_reg.talker) begin
         if (s_reg.poll_mode) begin
            s_next.tx_valid = 1'b1;
            s_next.tx_byte  = status_byte;
            s_next.tx_src   = GAPC_TX_STATUS;
         end else if (s_reg.mask_pend) begin
            s_next.tx_valid = 1'b1;
            s_next.tx_byte  = {2'b00, s_reg.mask};
            s_next.tx_src   = GAPC_TX_MASK;
         end else if (!q_empty && s_reg.rd_wait) begin
            s_next.tx_valid = 1'b1;
            s_next.tx_byte  = q_rd_data;
            s_next.tx_src   = GAPC_TX_DATA;
         end
      end
      // Memory read data lags the pointer by one cycle
      s_next.rd_wait = !q_empty && !(s_reg.tx_valid && tx_take);

      // Leaving talker or changing poll mode withdraws an offered byte
      if (!s_next.talker || (s_next.poll_mode != s_reg.poll_mode)) begin
         s_next.tx_valid = 1'b0;
      end

      // Request follows the pending set after a poll acknowledge
      s_next.srq     = |(s_next.pending & s_next.mask);
      s_next.lamp    = s_next.srq;

      // Device clear: flush input first, clear-all next cycle
      if (dev_clear) begin
         s_next.flush = 1'b1;
      end
      if (s_reg.flush || clear_all_cmd) begin
         s_next.clear     = 1'b1;
         s_next.rd_ptr    = s_reg.wr_ptr;
         s_next.wr_ptr    = s_reg.wr_ptr;
         s_next.tx_valid  = 1'b0;
         s_next.mask_pend = 1'b0;
         s_next.rd_wait   = 1'b0;
      end

      // Interface clear
      if (ifc) begin
         s_next.talker    = 1'b0;
         s_next.listener  = 1'b0;
         s_next.poll_mode = 1'b0;
         s_next.tx_valid  = 1'b0;
      end

      // Ready is registered from the next pointers so it matches q_wr
      s_next.ready = !s_next.clear &&
                     !((s_next.wr_ptr[Q_AW] != s_next.rd_ptr[Q_AW]) &&
                       (s_next.wr_ptr[Q_AW-1:0] ==
                        s_next.rd_ptr[Q_AW-1:0]));
   end

   // State register; power-up empties queue and clears poll mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_reg           <= '0;
         s_reg.mask      <= MASK_RESET;
         s_reg.tx_byte   <= STATUS_RESET;
         s_reg.tx_src    <= GAPC_TX_IDLE;
         s_reg.ready     <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from state
   assign talker               = s_reg.talker;
   assign listener             = s_reg.listener;
   assign remote               = s_reg.remote;
   assign lockout              = s_reg.lockout;
   assign poll_mode            = s_reg.poll_mode;
   assign srq                  = s_reg.srq;
   assign service_request_lamp = s_reg.lamp;
   assign service_mask         = s_reg.mask;
   assign input_flush          = s_reg.flush;
   assign clear_pulse          = s_reg.clear;
   assign tx_valid             = s_reg.tx_valid;
   assign tx_byte              = s_reg.tx_byte;
   assign data_ready           = s_reg.ready;
endmodule

// ==== core/gapc_pkg.sv ====
// Purpose: Shared constants and types for the address/poll/clear block
// Assumes: One 20 MHz clock, decoded bus messages arrive as pulses
// Notes:   Status byte layout: bit 6 is the request-service bit
package gapc_pkg;
   localparam int          CAUSE_W        = 6;
   localparam int          BYTE_W         = 8;
   localparam logic [5:0]  MASK_RESET     = 6'h00;
   localparam logic [7:0]  STATUS_RESET   = 8'h00;
   localparam int          RSV_BIT        = 6;
   localparam int          Q_DEPTH        = 8;
   localparam int          Q_AW           = 3;
   localparam int          CLK_HZ         = 20_000_000;

   // Talker output source
   typedef enum logic [1:0] {
      GAPC_TX_IDLE   = 2'b00,
      GAPC_TX_DATA   = 2'b01,
      GAPC_TX_STATUS = 2'b10,
      GAPC_TX_MASK   = 2'b11
   } gapc_tx_t;
endpackage

// ==== core/gapc_queue_mem.sv ====
// Purpose: Small output queue storage with registered read data
// Assumes: Caller keeps write and read pointers
// Notes:   No reset on contents; pointers define validity
module gapc_queue_mem
   import gapc_pkg::*;
(
   // Clock
   input  wire logic                   clk,
   // Write side
   input  wire logic                   wr_en,
   input  wire logic [Q_AW-1:0]        wr_addr,
   input  wire logic [BYTE_W-1:0]      wr_data,
   // Read side
   input  wire logic [Q_AW-1:0]        rd_addr,
   output logic      [BYTE_W-1:0]      rd_data
);
   logic [BYTE_W-1:0] mem [Q_DEPTH];

   // Write and registered read
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
